// [verilog/kpi_pkg.sv]
/*
  Package for the keypad pin interrupt block: register offsets, field
  positions and reset values, plus the carrier struct for pin control.
  Assumes a 32-bit APB with word-aligned registers.
*/
package kpi_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] KPI_STATUS_CONTROL_OFF = 8'h00;
  localparam logic [7:0] KPI_PIN_ENABLE_OFF     = 8'h04;
  localparam logic [7:0] KPI_PORT_CONFIG_OFF    = 8'h08;
  localparam logic [7:0] KPI_PIN_LEVEL_OFF      = 8'h0C;

  // ----------------------------------------------------------------
  // status/control fields
  // ----------------------------------------------------------------
  localparam int KPI_TRIGGER_SELECT_BIT = 0;
  localparam int KPI_MASK_BIT           = 1;
  localparam int KPI_ACK_BIT            = 2;
  localparam int KPI_PENDING_BIT        = 3;

  // port config: bits 7:0 direction, 15:8 pullup enable
  localparam int KPI_DIR_LSB            = 0;
  localparam int KPI_PULLUP_LSB         = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  KPI_PIN_ENABLE_RST  = 8'h00;
  localparam logic [15:0] KPI_PORT_CONFIG_RST = 16'h0000;
  localparam logic        KPI_CTRL_BIT_RST    = 1'b0;
  localparam logic [7:0]  KPI_SYNC_RST        = 8'hFF;

  typedef struct packed {
    logic [7:0] pullup_on;
    logic [7:0] output_enable_n;
  } kpi_pin_ctrl_t;
endpackage

// [verilog/kpi_keypad_interrupt_unit.sv]
/*
  Keypad pin interrupt unit: eight active-low keypad inputs with enables,
  one shared latch, edge or edge-plus-level trigger, mask and acknowledge.
  Assumes an APB master on pclk, port pins arriving asynchronously, and
  break state and vector-fetch acknowledge supplied by the core.
*/
// Our own choices: register access over APB and the register addresses.
//
// How it works
// - one enable bit per keypad pin
// - enabled pin forces its pullup on
// - latch sets on first low after all high
// - edge mode ignores edge while another low
// - level mode holds request while any low
// - level mode clears after all high and acknowledge
// - vector fetch acknowledges and clears latch
// - writing acknowledge one clears the latch
// - later falling edge sets latch again
// - unmasked pending request goes to cpu
// - reset clears request and trigger select
// - edge mode acknowledge clears latch at once
// - pending flag readable, independent of mask
// - enabled pin forced to input
// - unmasked request wakes from wait
// - unmasked request wakes from stop, registered on pclk
// - break with clear enable lets clears act
// - break without clear enable protects status
// - status byte layout, acknowledge reads zero
// - eight read/write pin enable bits
`timescale 1ns/1ps
module kpi_keypad_interrupt_unit
  import kpi_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            keypad_input_pins,
  input  wire logic                  vector_fetch_ack,
  input  wire logic                  break_state,
  input  wire logic                  break_clear_enable,
  output logic                       cpu_irq_req,
  output logic                       wakeup_req,
  output kpi_pkg::kpi_pin_ctrl_t     pin_ctrl
);
  import kpi_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  keypad_pin_enable_reg;
  logic [7:0]  direction_reg;
  logic [7:0]  pullup_cfg_reg;
  logic        keypad_trigger_select_reg;
  logic        keypad_mask_reg;
  logic        latch_reg;
  logic [7:0]  sync1_reg;
  logic [7:0]  sync2_reg;
  logic        any_low_prev_reg;
  logic        latch_next;
  logic [31:0] read_next;
  logic        irq_next;
  logic [7:0]  pullup_next;
  logic [7:0]  oe_n_next;
  logic [7:0]  pin_level;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word compare: the two low address bits never pick a register
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  // any of the four implemented words
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = addr_hit(a, KPI_STATUS_CONTROL_OFF) |
                  addr_hit(a, KPI_PIN_ENABLE_OFF) |
                  addr_hit(a, KPI_PORT_CONFIG_OFF) |
                  addr_hit(a, KPI_PIN_LEVEL_OFF);
  endfunction

  // an enabled pin is low; the keys are active low
  function automatic logic enabled_low(input logic [7:0] level, input logic [7:0] enable);
    enabled_low = |(~level & enable);
  endfunction

  // a request stands while latched or while held low in level mode
  function automatic logic pending_of(input logic latched, input logic held);
    pending_of = latched | held;
  endfunction

  // status byte as software sees it; the acknowledge bit always reads zero
  function automatic logic [31:0] status_word(input logic pend, input logic mask, input logic trig);
    status_word                         = 32'h00000000;
    status_word[KPI_PENDING_BIT]        = pend;
    status_word[KPI_MASK_BIT]           = mask;
    status_word[KPI_TRIGGER_SELECT_BIT] = trig;
  endfunction

  // zero-extend a byte to the bus width
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // pins that get a pullup: keypad duty or software choice
  function automatic logic [7:0] pullup_mask(input logic [7:0] enable, input logic [7:0] cfg);
    pullup_mask = enable | cfg;
  endfunction

  // low enables the pin driver; a keypad pin never drives
  function automatic logic [7:0] drive_n(input logic [7:0] dir, input logic [7:0] enable);
    drive_n = ~(dir & ~enable);
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic ack_write;
  logic clear_allowed;
  logic acknowledge;
  logic any_low;
  logic edge_event;
  logic sel_status;
  logic sel_enable;
  logic sel_config;
  logic sel_level;
  logic ack_vector;
  logic ack_soft;

  // ----------------------------------------------------------------
  // register selects
  // ----------------------------------------------------------------
  assign sel_status = addr_hit(paddr, KPI_STATUS_CONTROL_OFF);
  assign sel_enable = addr_hit(paddr, KPI_PIN_ENABLE_OFF);
  assign sel_config = addr_hit(paddr, KPI_PORT_CONFIG_OFF);
  assign sel_level  = addr_hit(paddr, KPI_PIN_LEVEL_OFF);

  // writes act at the access edge that carries pready
  assign wr_en  = psel & penable & pwrite & pready;
  // reads are sampled in setup so the data stand with pready
  assign rd_en  = psel & ~penable & ~pwrite;
  assign mapped = addr_mapped(paddr);
  assign ack_write = wr_en & sel_status & pwdata[KPI_ACK_BIT];

  // ----------------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------------
  // break gating: clears act outside break or when allowed
  assign clear_allowed = ~break_state | break_clear_enable;
  assign ack_vector = vector_fetch_ack & clear_allowed;
  assign ack_soft   = ack_write & clear_allowed;
  // both acknowledges clear the same latch
  assign acknowledge = ack_vector | ack_soft;

  // ----------------------------------------------------------------
  // input synchroniser and detection
  // ----------------------------------------------------------------
  // first synchroniser stage
  // stages reset high like released keys, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= KPI_SYNC_RST;
    end else begin
      sync1_reg <= keypad_input_pins;
    end
  end

  // second stage, the only one that logic reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync2_reg <= KPI_SYNC_RST;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  assign any_low = enabled_low(sync2_reg, keypad_pin_enable_reg);
  assign edge_event = any_low & ~any_low_prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_low_prev_reg <= 1'b0;
    end else begin
      any_low_prev_reg <= any_low;
    end
  end

  // ----------------------------------------------------------------
  // shared latch
  // ----------------------------------------------------------------
  always_comb begin
    latch_next = latch_reg;
    if (acknowledge) begin
      latch_next = 1'b0;
    end
    if (edge_event) begin
      latch_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= KPI_CTRL_BIT_RST;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // pending includes held low in level mode
  logic level_hold;
  logic pending;
  // a low enabled pin keeps the request only in level mode
  assign level_hold = keypad_trigger_select_reg & any_low;
  assign pending    = pending_of(latch_reg, level_hold);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // trigger select, cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keypad_trigger_select_reg <= KPI_CTRL_BIT_RST;
    end else if (wr_en && sel_status) begin
      keypad_trigger_select_reg <= pwdata[KPI_TRIGGER_SELECT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keypad_mask_reg <= KPI_CTRL_BIT_RST;
    end else if (wr_en && sel_status) begin
      keypad_mask_reg <= pwdata[KPI_MASK_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keypad_pin_enable_reg <= KPI_PIN_ENABLE_RST;
    end else if (wr_en && addr_hit(paddr, KPI_PIN_ENABLE_OFF)) begin
      keypad_pin_enable_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // port configuration
  // ----------------------------------------------------------------
  // direction per pin, one means output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_reg <= KPI_PORT_CONFIG_RST[KPI_DIR_LSB +: 8];
    end else if (wr_en && sel_config) begin
      direction_reg <= pwdata[KPI_DIR_LSB +: 8];
    end
  end

  // software pullup choice per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_cfg_reg <= KPI_PORT_CONFIG_RST[KPI_PULLUP_LSB +: 8];
    end else if (wr_en && sel_config) begin
      pullup_cfg_reg <= pwdata[KPI_PULLUP_LSB +: 8];
    end
  end

  // ----------------------------------------------------------------
  // apb answer: no wait state, read data latched in setup
  // ----------------------------------------------------------------
  // answers the access that follows every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  // unmapped words refused together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // pin level readable only where direction is input
  assign pin_level = sync2_reg & ~direction_reg;

  always_comb begin
    read_next = 32'h00000000;
    if (sel_status) begin
      read_next = status_word(pending, keypad_mask_reg, keypad_trigger_select_reg);
    end else if (sel_enable) begin
      read_next = byte_word(keypad_pin_enable_reg);
    end else if (sel_config) begin
      read_next = {16'h0000, pullup_cfg_reg, direction_reg};
    end else if (sel_level) begin
      read_next = byte_word(pin_level);
    end
  end

  // read data stay until the next read, so they stand with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= read_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // request is pending and not masked
  assign irq_next = pending & ~keypad_mask_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_req <= 1'b0;
    end else begin
      cpu_irq_req <= irq_next;
    end
  end

  // wake request from unmasked pending
  // taken on pclk: the clock of this unit must keep running in stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_req <= 1'b0;
    end else begin
      wakeup_req <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // pin control
  // ----------------------------------------------------------------
  always_comb begin
    pullup_next = pullup_mask(keypad_pin_enable_reg, pullup_cfg_reg);
    oe_n_next   = drive_n(direction_reg, keypad_pin_enable_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ctrl <= '{pullup_on: 8'h00, output_enable_n: 8'hFF};
    end else begin
      pin_ctrl <= '{pullup_on: pullup_next, output_enable_n: oe_n_next};
    end
  end
endmodule

// [test/kpi_props.sv]
/* Checker for the keypad pin interrupt unit, watching its ports only.
   Assumes a bind from the bench top and APB on pclk. */
`timescale 1ns/1ps
module kpi_props
  import kpi_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [7:0]    keypad_input_pins,
  input wire logic          vector_fetch_ack,
  input wire logic          break_state,
  input wire logic          break_clear_enable,
  input wire logic          cpu_irq_req,
  input wire logic          wakeup_req,
  input wire kpi_pin_ctrl_t pin_ctrl
);
  logic [7:0] en_q;
  logic       mask_q;
  wire        wr_ok = psel & penable & pready & pwrite & ~pslverr;
  // shadow of enables and mask as software wrote them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= 8'h00;
      mask_q <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == KPI_PIN_ENABLE_OFF) en_q <= pwdata[7:0];
      if (paddr == KPI_STATUS_CONTROL_OFF) mask_q <= pwdata[KPI_MASK_BIT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_next_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  bad_addr_a: assert property (pready && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  status_read_a: assert property (pready && !pwrite && paddr == KPI_STATUS_CONTROL_OFF
    |-> prdata[31:4] == 0 && !prdata[KPI_ACK_BIT]) else $error("status unused bits not zero");
  wake_match_a: assert property (wakeup_req == cpu_irq_req) else $error("wakeup differs from request");
  mask_block_a: assert property (mask_q && $past(mask_q) |-> !cpu_irq_req) else $error("masked request seen");
  pullup_force_a: assert property ((en_q & $past(en_q) & ~pin_ctrl.pullup_on) == 0)
    else $error("enabled pin lacks pullup");
  input_force_a: assert property ((en_q & $past(en_q) & ~pin_ctrl.output_enable_n) == 0)
    else $error("enabled pin driven");
  reset_quiet_a: assert property ($rose(presetn) |-> !cpu_irq_req [*3]) else $error("request after reset");
  cover property ($rose(cpu_irq_req));
  cover property (pready && pslverr);
  cover property (vector_fetch_ack && cpu_irq_req);
endmodule

// [test/kpi_key_model.sv]
/* Keys on the keypad pins: a pressed key pulls its pin low.
   Assumes press changes just after pclk edges. */
`timescale 1ns/1ps
module kpi_key_model (
  input  wire logic       pclk,
  input  wire logic [7:0] press,
  input  wire logic [7:0] pullup_on,
  output logic      [7:0] pins
);
  initial pins = 8'hFF;
  // released pin without pullup reads low, the inverse of its idle level
  always @(posedge pclk) pins <= ~press & pullup_on;
endmodule

// [test/kpi_keypad_pin_interrupt_bench.sv]
/* Bench for the keypad pin interrupt unit: APB tasks, key model, checker.
   Assumes the unit answers each APB access in one access cycle. */
`timescale 1ns/1ps
module kpi_keypad_pin_interrupt_bench;
  import kpi_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, err;
  logic [7:0]    keypad_input_pins;
  logic [7:0]    press = 8'h00;
  logic          vector_fetch_ack = 1'b0;
  logic          break_state = 1'b0;
  logic          break_clear_enable = 1'b0;
  logic          cpu_irq_req, wakeup_req;
  kpi_pin_ctrl_t pin_ctrl;
  int            error_cnt = 0;
  int            tests_run = 0;
  int            cyc = 0;
  always #50 pclk = ~pclk;
  kpi_keypad_interrupt_unit u_dut (.*);
  kpi_key_model u_keys (.pclk(pclk), .press(press), .pullup_on(pin_ctrl.pullup_on), .pins(keypad_input_pins));
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic t_regs;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    wr(8'h04, 32'hFF);
    rdchk(8'h04, 32'hFF);
    wr(8'h04, 32'h0);
    rdchk(8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(8'h00, 32'h7);
    rdchk(8'h00, 32'h3);
    wr(8'h00, 32'h0);
    $display("registers done");
  endtask
  task automatic t_edge;
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h6);
    wr(8'h00, 32'h0);
    rdchk(8'h00, 32'h0);
    press <= 8'h01;
    tick(8);
    check({31'h0, cpu_irq_req}, 32'h1);
    check({31'h0, wakeup_req}, 32'h1);
    rdchk(8'h00, 32'h8);
    wr(8'h00, 32'h4);
    press <= 8'h03;
    tick(8);
    rdchk(8'h00, 32'h0);
    press <= 8'h00;
    tick(8);
    press <= 8'h02;
    tick(8);
    rdchk(8'h00, 32'h8);
    wr(8'h00, 32'h2);
    rdchk(8'h00, 32'hA);
    check({31'h0, cpu_irq_req}, 32'h0);
    wr(8'h00, 32'h6);
    rdchk(8'h00, 32'h2);
    press <= 8'h00;
    wr(8'h00, 32'h0);
    $display("edge mode done");
  endtask
  task automatic t_level;
    wr(8'h00, 32'h1);
    press <= 8'h01;
    tick(8);
    wr(8'h00, 32'h5);
    rdchk(8'h00, 32'h9);
    press <= 8'h00;
    tick(8);
    rdchk(8'h00, 32'h1);
    press <= 8'h01;
    tick(8);
    press <= 8'h00;
    tick(8);
    rdchk(8'h00, 32'h9);
    wr(8'h00, 32'h5);
    rdchk(8'h00, 32'h1);
    press <= 8'h01;
    tick(8);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    check({31'h0, cpu_irq_req}, 32'h0);
    rdchk(8'h00, 32'h0);
    press <= 8'h00;
    $display("level mode done");
  endtask
  task automatic t_vec_brk;
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h4);
    press <= 8'h01;
    tick(8);
    vector_fetch_ack <= 1'b1;
    tick(1);
    vector_fetch_ack <= 1'b0;
    tick(3);
    rdchk(8'h00, 32'h0);
    press <= 8'h00;
    tick(8);
    press <= 8'h01;
    tick(8);
    break_state <= 1'b1;
    wr(8'h00, 32'h4);
    rdchk(8'h00, 32'h8);
    break_clear_enable <= 1'b1;
    wr(8'h00, 32'h4);
    break_state <= 1'b0;
    break_clear_enable <= 1'b0;
    tick(2);
    rdchk(8'h00, 32'h0);
    wr(8'h08, 32'h000000FF);
    tick(2);
    check({24'h0, pin_ctrl.output_enable_n}, 32'h01);
    check({24'h0, pin_ctrl.pullup_on}, 32'h01);
    rdchk(8'h0C, 32'h0);
    wr(8'h08, 32'h0000FF00);
    tick(4);
    rdchk(8'h0C, 32'hFE);
    press <= 8'h00;
    $display("vector, break and pins done");
  endtask
  initial begin
    tick(3);
    presetn <= 1'b1;
    tick(1);
    t_regs();
    t_edge();
    t_level();
    t_vec_brk();
    finish_test();
  end
endmodule
bind kpi_keypad_interrupt_unit kpi_props u_props (.*);
